// file: sim/link_ctrl_model.sv
// Purpose: Link-side model that drives the serial request line
// Assumes: Caller frames each request, MSB first
// Notes:   Line idles low; idle() holds it low for gaps between requests
`timescale 1ns/100ps
module link_ctrl_model
(
  input  wire logic sys_clk,
  output logic      serial_request_line
);
  // ----
  // Sender
  // ----
  initial serial_request_line = 1'b0;

  // Bus, register and acceleration requests, one bit a clock
  task automatic send(input logic [16:0] bits, input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      @(posedge sys_clk);
      serial_request_line <= bits[i];
    end
  endtask

  task automatic idle(input int n);
    repeat (n)
    begin
      @(posedge sys_clk);
      serial_request_line <= 1'b0;
    end
  endtask
endmodule

// file: sim/phy_link_request_compat_bench.sv
// Purpose: Self-checking bench for the request decoder
// Assumes: Link model sends requests; bench drives reset, bus reset and rx data
// Notes:   Kinds, legacy codes and rx bytes random from a fixed seed; extended codes swept in order
`timescale 1ns/100ps
module phy_link_request_compat_bench
  import phy_link_req_pkg::*;
;
  logic              sys_clk;
  logic              rst;
  logic              serial_request_line;
  logic              bus_reset;
  logic              rx_valid;
  logic [DATA_W-1:0] rx_data;
  logic              bus_req_valid_reg;
  logic [1:0]        bus_req_kind_reg;
  logic [1:0]        bus_req_speed_reg;
  logic              null_packet_reg;
  logic              rd_valid_reg;
  logic [3:0]        rd_addr_reg;
  logic [DATA_W-1:0] rd_data_reg;
  logic              arb_accel_active_reg;
  logic              mixed_concat_allow_reg;
  logic [1:0]        selfid_speed_reg;
  logic [1:0]        peer_speed_reg;
  logic              link_rx_valid_reg;
  logic [DATA_W-1:0] link_rx_data_reg;
  int                failures = 0;
  int                samples_checked = 0;
  int                bus_n = 0;
  int                null_n = 0;
  int                ev_n = 0;
  int                rd_n = 0;
  logic [1:0]        last_kind;
  logic [1:0]        last_speed;
  logic [DATA_W-1:0] last_rd;
  logic [3:0]        last_addr;
  logic              chk_rx = 1'b0;
  logic              prev_v;
  logic [DATA_W-1:0] prev_d;
  logic [1:0]        spd = SPD_S400;

  phy_link_request_compat dut (
    .sys_clk                (sys_clk),
    .rst                    (rst),
    .serial_request_line    (serial_request_line),
    .bus_reset              (bus_reset),
    .rx_valid               (rx_valid),
    .rx_data                (rx_data),
    .bus_req_valid_reg      (bus_req_valid_reg),
    .bus_req_kind_reg       (bus_req_kind_reg),
    .bus_req_speed_reg      (bus_req_speed_reg),
    .null_packet_reg        (null_packet_reg),
    .rd_valid_reg           (rd_valid_reg),
    .rd_addr_reg            (rd_addr_reg),
    .rd_data_reg            (rd_data_reg),
    .arb_accel_active_reg   (arb_accel_active_reg),
    .mixed_concat_allow_reg (mixed_concat_allow_reg),
    .selfid_speed_reg       (selfid_speed_reg),
    .peer_speed_reg         (peer_speed_reg),
    .link_rx_valid_reg      (link_rx_valid_reg),
    .link_rx_data_reg       (link_rx_data_reg)
  );
  link_ctrl_model link (
    .sys_clk             (sys_clk),
    .serial_request_line (serial_request_line)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // ----
  // Checking helpers
  // ----
  function automatic logic [1:0] exp_speed(input logic [2:0] c);
    return c[2:1];
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %0t %s: seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Bounded wait; a stuck decoder ends the run
  task automatic wait_for(ref int cnt, input int want);
    for (int i = 0; i < 30 && cnt < want; i++)
      @(negedge sys_clk);
    if (cnt < want)
    begin
      failures++;
      wrap_up();
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    link.send({1'b1, REQ_WR_REG, a, d, 1'b0}, 17);
    link.idle(2);
    // Outputs settle after the edge; look mid-cycle
    @(negedge sys_clk);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    int r0;
    r0 = rd_n;
    link.send({8'h00, 1'b1, REQ_RD_REG, a, 1'b0}, 9);
    wait_for(rd_n, r0 + 1);
    check(last_rd, exp, "read data");
    check(last_addr, a, "read addr");
  endtask

  // ----
  // Monitor; pulses last one cycle so they are counted here
  // ----
  always @(posedge sys_clk)
  begin
    if (bus_req_valid_reg === 1'b1)
    begin
      bus_n++;
      ev_n++;
      last_kind = bus_req_kind_reg;
      last_speed = bus_req_speed_reg;
    end
    if (null_packet_reg === 1'b1)
    begin
      null_n++;
      ev_n++;
    end
    if (rd_valid_reg === 1'b1)
    begin
      rd_n++;
      last_rd = rd_data_reg;
      last_addr = rd_addr_reg;
    end
    if (chk_rx)
    begin
      check(link_rx_valid_reg, prev_v, "rx valid");
      check(link_rx_data_reg, prev_d, "rx data");
    end
    prev_v = rx_valid;
    prev_d = rx_data;
  end

  // ----
  // Main sequence
  // ----
  initial
  begin
    logic [1:0] kind;
    logic [2:0] code;
    int         b0;
    int         n0;
    rst = 1'b1;
    bus_reset = 1'b0;
    rx_valid = 1'b0;
    rx_data = '0;
    void'($urandom(32'h6DA3D293));
    repeat (16) @(posedge sys_clk); // Scaled stand-in for the long power-on hold
    @(negedge sys_clk);
    check(selfid_speed_reg, SPD_S400, "selfid at reset");
    check(peer_speed_reg, SPD_S400, "peer at reset");
    check(arb_accel_active_reg, 1'b0, "accel at reset");
    check(mixed_concat_allow_reg, 1'b0, "concat at reset");
    @(posedge sys_clk);
    rst <= 1'b0;
    // Leaf setup writes link speed first; 3 is illegal and refused
    wr(ADDR_PAGE, {PAGE_VENDOR, 5'h00});
    for (int s = 3; s >= 0; s--)
    begin
      wr(ADDR_LSPEED, {2'(s), 6'h00});
      if (s != 3)
        spd = 2'(s);
      check(selfid_speed_reg, spd, "selfid speed");
      check(peer_speed_reg, SPD_S400, "peer speed");
    end
    wr(ADDR_PAGE, 8'h00);
    wr(ADDR_LSPEED, 8'h80);
    check(selfid_speed_reg, spd, "write off page");
    wr(ADDR_PAGE, {PAGE_VENDOR, 5'h00});
    @(posedge sys_clk);
    bus_reset <= 1'b1;
    link.idle(3);
    bus_reset <= 1'b0;
    link.idle(2);
    check(selfid_speed_reg, spd, "speed after bus reset");
    rd(ADDR_LSPEED, {spd, 6'h00});
    rd(4'hC, 8'h00);
    // Every extended code, each awaited before the next is sent
    for (int c = 0; c < 8; c++)
    begin
      code = 3'(c);
      kind = 2'($urandom);
      b0 = bus_n;
      n0 = null_n;
      link.send({1'b1, 1'b0, kind, code, 1'b0}, 8);
      wait_for(ev_n, b0 + n0 + 1);
      check(bus_n - b0, code <= CODE_S400, "bus accept");
      check(null_n - n0, code > CODE_S400, "null packet");
      if (code <= CODE_S400)
      begin
        check(last_speed, exp_speed(code), "ext speed");
        check(last_kind, kind, "ext kind");
      end
    end
    // Legacy form chained straight into a register read
    repeat (3)
    begin
      code = {2'($urandom % 3), 1'b0};
      kind = 2'($urandom);
      b0 = bus_n;
      n0 = rd_n;
      link.send({1'b1, 1'b0, kind, code[2:1], 1'b0}, 7);
      rd(ADDR_LSPEED, {spd, 6'h00});
      wait_for(bus_n, b0 + 1);
      check(last_speed, exp_speed(code), "legacy speed");
      check(last_kind, kind, "legacy kind");
      link.idle(2);
    end
    // Acceleration needs the enable bit; concat follows its bit
    link.send({1'b1, REQ_ACCEL, 1'b1, 1'b0}, 6);
    link.idle(2);
    @(negedge sys_clk);
    check(arb_accel_active_reg, 1'b0, "accel gated");
    wr(ADDR_FEAT, 8'h03);
    check(arb_accel_active_reg, 1'b1, "accel on");
    check(mixed_concat_allow_reg, 1'b1, "concat on");
    link.send({1'b1, REQ_ACCEL, 1'b0, 1'b0}, 6);
    link.idle(2);
    @(negedge sys_clk);
    check(arb_accel_active_reg, 1'b0, "accel off");
    wr(ADDR_FEAT, 8'h02);
    check(mixed_concat_allow_reg, 1'b0, "concat off");
    // Receive data at a slow link speed still passes unfiltered
    repeat (40)
    begin
      @(posedge sys_clk);
      chk_rx <= 1'b1;
      rx_valid <= 1'($urandom);
      rx_data <= DATA_W'($urandom);
    end
    @(posedge sys_clk);
    chk_rx <= 1'b0;
    link.idle(2);
    wrap_up();
  end
endmodule

// file: src/phy_link_req_pkg.sv
// Purpose: Shared constants for the request-line decoder and its data path
// Assumes: One clock, all link-side inputs already synchronous
// Notes:   Speed codes are the 3-bit extended form; legacy codes are its top two bits
package phy_link_req_pkg;

  // ----------------------------------------------------------------------
  // Request types carried after the start bit
  // ----------------------------------------------------------------------
  localparam logic [2:0] REQ_IMM      = 3'h0;
  localparam logic [2:0] REQ_FAIR_MAX = 3'h3;
  localparam logic [2:0] REQ_RD_REG   = 3'h4;
  localparam logic [2:0] REQ_WR_REG   = 3'h5;
  localparam logic [2:0] REQ_ACCEL    = 3'h6;

  // ----------------------------------------------------------------------
  // Field lengths in bits (body lengths include the stop bit)
  // ----------------------------------------------------------------------
  localparam logic [3:0] TYPE_BITS    = 4'h3;
  localparam logic [3:0] SPEED_BITS   = 4'h3;
  localparam logic [3:0] RD_BODY_BITS = 4'h5;
  localparam logic [3:0] WR_BODY_BITS = 4'hD;
  localparam logic [3:0] AC_BODY_BITS = 4'h2;

  // ----------------------------------------------------------------------
  // Speeds
  // ----------------------------------------------------------------------
  localparam logic [1:0] SPD_S100    = 2'h0;
  localparam logic [1:0] SPD_S200    = 2'h1;
  localparam logic [1:0] SPD_S400    = 2'h2;
  localparam logic [1:0] SPD_ILLEGAL = 2'h3;
  localparam logic [2:0] CODE_S400   = 3'h4;

  // ----------------------------------------------------------------------
  // Register map reached by read and write requests
  // ----------------------------------------------------------------------
  localparam logic [3:0] ADDR_FEAT    = 4'h5;
  localparam logic [3:0] ADDR_PAGE    = 4'h7;
  localparam logic [3:0] ADDR_LSPEED  = 4'h8;
  localparam logic [2:0] PAGE_VENDOR  = 3'h7;
  localparam int         FEAT_ACC_BIT = 1;
  localparam int         FEAT_MSC_BIT = 0;
  localparam int         PAGE_LSB     = 5;
  localparam int         LSPEED_LSB   = 6;
  localparam int         DATA_W       = 8;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_TYPE,
    ST_SPEED,
    ST_STOP,
    ST_BODY
  } req_state_t;

  // Extended code to internal speed; S100..S400 agree with legacy codes
  function automatic logic [1:0] code_to_speed(input logic [2:0] code);
    code_to_speed = code[2:1];
  endfunction

  function automatic logic code_above_s400(input logic [2:0] code);
    code_above_s400 = (code > CODE_S400);
  endfunction

endpackage

// file: src/phy_link_request_compat.sv
// Purpose: Request-line decoder and link compatibility controls of the physical layer
// Assumes: serial_request_line sampled on sys_clk; rst is the hardware reset
// Notes:   Feature bits and link speed are written through register requests
//
// Contract
// [RULE_01] Arbitration acceleration stays off unless its enable bit is set.
// [RULE_02] Mixed-speed concatenation stays off unless its enable bit is set.
// [RULE_03] Bus requests are accepted in both the 7-bit and the 8-bit form.
// [RULE_04] A legacy bus request directly followed by another request decodes both.
// [RULE_05] An extended bus request above S400 yields a null packet.
// [RULE_06] All received packet data goes to the link, whatever its speed.
// [RULE_07] The link-speed field changes only the self-ID speed; peers always see S400.
// [RULE_08] The link-speed field powers up holding the S400 code.
// [RULE_09] Leaf-only systems should write the link-speed field right after reset.
// [RULE_10] The reset driver holds reset for at least 2 ms after supply is good.
// [RULE_11] Link speed encodes 00 S100, 01 S200, 10 S400, 11 illegal; bus reset keeps it.
// [RULE_12] The link uses the request line for bus, register and acceleration requests.
// [RULE_13] Formats differ by length and both map to one internal speed value.
`timescale 1ns/100ps
module phy_link_request_compat
  import phy_link_req_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              serial_request_line,
  input  wire logic              bus_reset,
  input  wire logic              rx_valid,
  input  wire logic [DATA_W-1:0] rx_data,
  output logic                   bus_req_valid_reg,
  output logic [1:0]             bus_req_kind_reg,
  output logic [1:0]             bus_req_speed_reg,
  output logic                   null_packet_reg,
  output logic                   rd_valid_reg,
  output logic [3:0]             rd_addr_reg,
  output logic [DATA_W-1:0]      rd_data_reg,
  output logic                   arb_accel_active_reg,
  output logic                   mixed_concat_allow_reg,
  output logic [1:0]             selfid_speed_reg,
  output logic [1:0]             peer_speed_reg,
  output logic                   link_rx_valid_reg,
  output logic [DATA_W-1:0]      link_rx_data_reg
);

  req_state_t        state_reg;
  logic [3:0]        cnt_reg;
  logic [2:0]        type_reg;
  logic [2:0]        code_reg;
  logic [12:0]       body_reg;
  logic [3:0]        body_len_reg;
  logic              arb_accel_enable;
  logic              multispeed_concat_enable;
  logic              accel_ctl_on_reg;
  logic [2:0]        page_reg;
  logic [1:0]        link_speed_reg;
  logic              issue_bus;
  logic              body_done;
  logic [12:0]       body_next;
  logic [2:0]        code_next;

  // ----------------------------------------------------------------------
  // Request framing
  // ----------------------------------------------------------------------
  assign code_next = {code_reg[1:0], serial_request_line};
  assign body_next = {body_reg[11:0], serial_request_line};
  assign body_done = (state_reg == ST_BODY) && (cnt_reg == body_len_reg - 4'h1);
  assign issue_bus = (state_reg == ST_STOP);

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg    <= ST_IDLE;
      cnt_reg      <= '0;
      type_reg     <= '0;
      code_reg     <= '0;
      body_reg     <= '0;
      body_len_reg <= '0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          cnt_reg <= '0;
          if (serial_request_line)
            state_reg <= ST_TYPE;
        end
        ST_TYPE:
        begin
          type_reg <= {type_reg[1:0], serial_request_line};
          cnt_reg  <= cnt_reg + 4'h1;
          if (cnt_reg == TYPE_BITS - 4'h1)
          begin
            cnt_reg  <= '0;
            body_reg <= '0;
            case ({type_reg[1:0], serial_request_line})
              REQ_RD_REG: begin state_reg <= ST_BODY; body_len_reg <= RD_BODY_BITS; end
              REQ_WR_REG: begin state_reg <= ST_BODY; body_len_reg <= WR_BODY_BITS; end
              REQ_ACCEL:  begin state_reg <= ST_BODY; body_len_reg <= AC_BODY_BITS; end
              default:
              begin
                // Bus request types fall below the register types
                if ({type_reg[1:0], serial_request_line} <= REQ_FAIR_MAX)
                  state_reg <= ST_SPEED;
                else
                  state_reg <= ST_IDLE;
              end
            endcase
          end
        end
        ST_SPEED:
        begin
          // Third speed bit doubles as the legacy stop bit
          code_reg <= code_next;  // [RULE_03]
          cnt_reg  <= cnt_reg + 4'h1;
          if (cnt_reg == SPEED_BITS - 4'h1)
            state_reg <= ST_STOP;
        end
        ST_STOP:
        begin
          cnt_reg <= '0;
          // A one after a 7-bit request is the next start bit
          if (!code_reg[0] && serial_request_line)
            state_reg <= ST_TYPE;  // [RULE_04] [RULE_13]
          else
            state_reg <= ST_IDLE;
        end
        ST_BODY:
        begin
          body_reg <= body_next;
          cnt_reg  <= cnt_reg + 4'h1;
          if (body_done)
            state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Bus request issue
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      bus_req_valid_reg <= 1'b0;
      bus_req_kind_reg  <= '0;
      bus_req_speed_reg <= SPD_S100;
      null_packet_reg   <= 1'b0;
    end
    else
    begin
      bus_req_valid_reg <= issue_bus && !code_above_s400(code_reg);  // [RULE_03]
      null_packet_reg   <= issue_bus && code_above_s400(code_reg);   // [RULE_05]
      if (issue_bus)
      begin
        bus_req_kind_reg  <= type_reg[1:0];
        bus_req_speed_reg <= code_to_speed(code_reg);  // [RULE_13]
      end
    end
  end

  // ----------------------------------------------------------------------
  // Register writes, reads and acceleration control
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      arb_accel_enable         <= 1'b0;
      multispeed_concat_enable <= 1'b0;
      page_reg                 <= '0;
      link_speed_reg           <= SPD_S400;  // [RULE_08] [RULE_11]
      accel_ctl_on_reg         <= 1'b0;
    end
    else if (body_done && type_reg == REQ_WR_REG)
    begin
      // Full 4-bit address; a 3-bit slice would alias register 8 onto 0
      case (body_next[DATA_W+4:DATA_W+1])
        ADDR_FEAT:
        begin
          arb_accel_enable         <= body_next[FEAT_ACC_BIT+1];
          multispeed_concat_enable <= body_next[FEAT_MSC_BIT+1];
        end
        ADDR_PAGE: page_reg <= body_next[PAGE_LSB+3:PAGE_LSB+1];
        ADDR_LSPEED:
        begin
          // Illegal code is refused so the self-ID never carries it
          if (page_reg == PAGE_VENDOR && body_next[LSPEED_LSB+2:LSPEED_LSB+1] != SPD_ILLEGAL)
            link_speed_reg <= body_next[LSPEED_LSB+2:LSPEED_LSB+1];  // [RULE_11]
        end
        default: ;
      endcase
    end
    else if (body_done && type_reg == REQ_ACCEL)
      accel_ctl_on_reg <= body_next[1];
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rd_valid_reg <= 1'b0;
      rd_addr_reg  <= '0;
      rd_data_reg  <= '0;
    end
    else
    begin
      rd_valid_reg <= body_done && type_reg == REQ_RD_REG;
      if (body_done && type_reg == REQ_RD_REG)
      begin
        rd_addr_reg <= body_next[4:1];
        case (body_next[4:1])
          ADDR_FEAT:   rd_data_reg <= DATA_W'({arb_accel_enable, multispeed_concat_enable});
          ADDR_PAGE:   rd_data_reg <= DATA_W'({page_reg, 5'h00});
          ADDR_LSPEED: rd_data_reg <= (page_reg == PAGE_VENDOR) ?
                                      DATA_W'({link_speed_reg, 6'h00}) : '0;
          default:     rd_data_reg <= '0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Feature gating and self-ID speeds
  // ----------------------------------------------------------------------
  // Bus reset deliberately has no effect on link speed
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      arb_accel_active_reg   <= 1'b0;
      mixed_concat_allow_reg <= 1'b0;
      selfid_speed_reg       <= SPD_S400;
      peer_speed_reg         <= SPD_S400;
    end
    else
    begin
      arb_accel_active_reg   <= arb_accel_enable && accel_ctl_on_reg;  // [RULE_01]
      mixed_concat_allow_reg <= multispeed_concat_enable;              // [RULE_02]
      selfid_speed_reg       <= link_speed_reg;                        // [RULE_07]
      peer_speed_reg         <= SPD_S400;                              // [RULE_07]
    end
  end

  rx_data_forward u_rx_fwd (
    .sys_clk       (sys_clk),
    .rst           (rst),
    .in_valid      (rx_valid),
    .in_data       (rx_data),
    .out_valid_reg (link_rx_valid_reg),
    .out_data_reg  (link_rx_data_reg)
  );

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  accel_gated_a: assert property (arb_accel_active_reg |-> $past(arb_accel_enable))  // [RULE_01]
    else $error("acceleration active without enable");
  concat_gated_a: assert property (mixed_concat_allow_reg == $past(multispeed_concat_enable))  // [RULE_02]
    else $error("concatenation permission not following enable");
  bus_issue_a: assert property (issue_bus && !code_above_s400(code_reg)
                                |=> bus_req_valid_reg && !null_packet_reg)  // [RULE_03]
    else $error("bus request not issued");
  legacy_chain_a: assert property (state_reg == ST_STOP && !code_reg[0] && serial_request_line
                                   |=> state_reg == ST_TYPE ##3 state_reg != ST_IDLE)  // [RULE_04]
    else $error("request after short bus request lost");
  null_packet_a: assert property (issue_bus && code_above_s400(code_reg)
                                  |=> null_packet_reg && !bus_req_valid_reg)  // [RULE_05]
    else $error("oversped request without null packet");
  rx_forward_a: assert property (rx_valid |=> link_rx_valid_reg && link_rx_data_reg == $past(rx_data))  // [RULE_06]
    else $error("received data not forwarded");
  peer_speed_a: assert property (peer_speed_reg == SPD_S400 && selfid_speed_reg != SPD_ILLEGAL)  // [RULE_07]
    else $error("peer speed not S400 or illegal self-ID speed");
  lspeed_bus_reset_a: assert property (bus_reset && !body_done |=> $stable(link_speed_reg))  // [RULE_11]
    else $error("link speed changed without a write");
  speed_map_a: assert property (issue_bus |=> bus_req_speed_reg == $past(code_reg[2:1]) || null_packet_reg)  // [RULE_13]
    else $error("speed code decoded wrongly");

endmodule

// file: src/rx_data_forward.sv
// Purpose: One-stage forwarding of received packet data toward the link
// Assumes: Data and valid arrive together from the serial receiver
// Notes:   Deliberately has no speed filter
`timescale 1ns/100ps
module rx_data_forward
  import phy_link_req_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              in_valid,
  input  wire logic [DATA_W-1:0] in_data,
  output logic                   out_valid_reg,
  output logic [DATA_W-1:0]      out_data_reg
);

  // Oversped packets go through too; the link drops what it cannot take
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      out_valid_reg <= 1'b0;
      out_data_reg  <= '0;
    end
    else
    begin
      out_valid_reg <= in_valid;  // [RULE_06]
      out_data_reg  <= in_data;   // [RULE_06]
    end
  end

endmodule
